// ### psos_pkg.sv
// package: register map, codes and scaling constants of the status output selector
package psos_pkg;

  // ----------------------------------------------------------------
  // register map (word addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [3:0] PSOS_ADDR_FUNC_A   = 4'h0;
  localparam logic [3:0] PSOS_ADDR_FUNC_B   = 4'h1;
  localparam logic [3:0] PSOS_ADDR_PSCALE_A = 4'h2;
  localparam logic [3:0] PSOS_ADDR_PSCALE_B = 4'h3;
  localparam logic [3:0] PSOS_ADDR_BUSPCT_A = 4'h4;
  localparam logic [3:0] PSOS_ADDR_BUSPCT_B = 4'h5;
  localparam logic [3:0] PSOS_ADDR_STATUS   = 4'h6;
  localparam logic [7:0]  PSOS_FUNC_RST   = 8'h00;
  localparam logic [15:0] PSOS_PSCALE_RST = 16'h1388;
  localparam logic [15:0] PSOS_PSCALE_MAX = 16'h7d00;
  localparam logic [9:0]  PSOS_BUSPCT_MAX = 10'h3e8;
  localparam logic [31:0] PSOS_UNMAPPED   = 32'hdead_0000;

  // ----------------------------------------------------------------
  // function codes
  // ----------------------------------------------------------------
  localparam logic [7:0] PSOS_F_LAST_DIG  = 8'h1c;
  localparam logic [7:0] PSOS_F_ANA_FIRST = 8'h1d;
  localparam logic [7:0] PSOS_F_ANA_LAST  = 8'h2e;
  localparam logic [7:0] PSOS_F_FIRE      = 8'h2f;
  localparam logic [7:0] PSOS_F_BYPASS    = 8'h30;

  // ----------------------------------------------------------------
  // scaling: 16-bit fraction of full scale, current in uA
  // ----------------------------------------------------------------
  localparam logic [15:0] PSOS_MA_ZERO   = 16'h0000;
  localparam logic [15:0] PSOS_MA_LIVE   = 16'h0fa0;
  localparam logic [15:0] PSOS_MA_FULL   = 16'h4e20;
  localparam logic [15:0] PSOS_HZ01      = 16'h0001;

  typedef enum logic [1:0] {
    PSOS_FORM_DIG   = 2'b00,
    PSOS_FORM_MA0   = 2'b01,
    PSOS_FORM_MA4   = 2'b11,
    PSOS_FORM_PULSE = 2'b10
  } psos_form_e;

  // drive state flags, one bit each
  typedef struct packed {
    logic ready;
    logic start_cmd;
    logic warning;
    logic alarm;
    logic at_ref;
    logic local_ref;
    logic interlock_in;
    logic interlock_cfg;
    logic reverse;
    logic thermal_warn;
    logic hand_mode;
    logic auto_mode;
    logic sleep_mode;
    logic freq_low;
    logic freq_high;
    logic cur_low;
    logic cur_high;
    logic fb_range;
    logic ref_range;
    logic option_relay;
    logic mains_imbal;
    logic fire_mode;
    logic fire_bypass;
  } psos_flags_s;

  // process values with their scaling limits, unsigned 16 bit
  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] max_freq;
    logic [15:0] ext_ref;
    logic [15:0] min_ref;
    logic [15:0] max_ref;
    logic [15:0] feedback;
    logic [15:0] min_feedback;
    logic [15:0] max_feedback;
    logic [15:0] current;
    logic [15:0] max_current;
    logic [15:0] current_limit_setting;
    logic [15:0] power;
    logic [15:0] nominal_power;
  } psos_proc_s;

  // one output channel as seen by the analog stage
  typedef struct packed {
    psos_form_e  form;
    logic        digital;
    logic [15:0] milliamp_ua;
    logic [15:0] pulse_hz;
  } psos_chan_s;

endpackage

// ### psos_selector.sv
// module: two-channel programmable status / process value output selector
module psos_selector
  import psos_pkg::*;
#(
  parameter int FRAC_W = 16
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire psos_flags_s flags,
  input  wire psos_proc_s  proc,
  output psos_chan_s       chan_a,
  output psos_chan_s       chan_b
);

  if (FRAC_W != 16) begin : g_frac_w_chk
    $error("psos_selector supports FRAC_W of 16 only");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  func_a;
    logic [7:0]  func_b;
    logic [15:0] pscale_a;
    logic [15:0] pscale_b;
    logic [9:0]  buspct_a;
    logic [9:0]  buspct_b;
    logic        ack;
    logic [31:0] rdata;
    psos_chan_s  ch_a;
    psos_chan_s  ch_b;
  } psos_state_s;

  psos_state_s st_r;
  psos_state_s st_nxt;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // fraction of (v - lo) over (hi - lo), clamped, 16-bit full scale
  function automatic logic [15:0] psos_frac(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
    logic [31:0] num;
    logic [31:0] q;
    num = 32'h0;
    q   = 32'h0;
    if (hi <= lo || v <= lo) return 16'h0000;
    if (v >= hi) return 16'hffff;
    num = {16'h0000, v - lo} << 16;
    q   = num / {16'h0000, hi - lo};
    return q[15:0];
  endfunction

  // status condition of a digital code
  function automatic logic psos_status(input logic [7:0] f, input psos_flags_s fl,
                                       input psos_proc_s p);
    logic run;
    run = fl.start_cmd || (p.out_freq > PSOS_HZ01);
    case (f)
      8'h01: return fl.ready;
      8'h02: return fl.ready && !fl.start_cmd && !fl.warning;
      8'h03: return run;
      8'h04: return run && fl.at_ref;
      8'h05: return fl.start_cmd && !fl.warning;
      8'h06: return fl.local_ref;
      8'h07: return !fl.local_ref;
      8'h08: return fl.alarm;
      8'h09: return fl.alarm || fl.warning;
      8'h0a: return !fl.alarm;
      8'h0b: return p.current > p.current_limit_setting;
      8'h0c: return fl.interlock_in && fl.interlock_cfg;
      8'h0d: return fl.start_cmd;
      8'h0e: return fl.reverse;
      8'h0f: return fl.thermal_warn;
      8'h10: return fl.hand_mode;
      8'h11: return fl.auto_mode;
      8'h12: return fl.sleep_mode;
      8'h13: return fl.freq_low;
      8'h14: return fl.freq_high;
      8'h15: return fl.freq_low || fl.freq_high;
      8'h16: return fl.cur_low;
      8'h17: return fl.cur_high;
      8'h18: return fl.cur_low || fl.cur_high;
      8'h19: return fl.fb_range;
      8'h1a: return fl.ref_range;
      8'h1b: return fl.option_relay;
      8'h1c: return fl.mains_imbal;
      8'h2f: return fl.fire_mode;
      8'h30: return fl.fire_bypass;
      default: return 1'b0;
    endcase
  endfunction

  // full channel value from a code
  function automatic psos_chan_s psos_chan(input logic [7:0] f, input logic [15:0] ps,
                                           input logic [9:0] pct, input psos_flags_s fl,
                                           input psos_proc_s p);
    psos_chan_s c;
    logic [15:0] fr;
    logic [7:0]  idx;
    logic [1:0]  sub;
    logic [31:0] t;
    c   = '{form: PSOS_FORM_DIG, digital: 1'b0, milliamp_ua: PSOS_MA_ZERO, pulse_hz: 16'h0};
    fr  = 16'h0;
    t   = 32'h0;
    idx = 8'h0;
    sub = 2'b00;
    if (f >= PSOS_F_ANA_FIRST && f <= PSOS_F_ANA_LAST) begin
      idx = (f - PSOS_F_ANA_FIRST) / 8'd3;
      sub = 2'((f - PSOS_F_ANA_FIRST) % 8'd3);
      case (idx)
        8'h00: fr = psos_frac(p.out_freq, 16'h0, p.max_freq);
        8'h01: fr = psos_frac(p.ext_ref, p.min_ref, p.max_ref);
        8'h02: fr = psos_frac(p.feedback, p.min_feedback, p.max_feedback);
        8'h03: fr = psos_frac(p.current, 16'h0, p.max_current);
        8'h04: fr = psos_frac(p.power, 16'h0, p.nominal_power);
        default: fr = psos_frac({6'h0, pct}, 16'h0, {6'h0, PSOS_BUSPCT_MAX});
      endcase
      case (sub)
        2'b00: begin
          c.form = PSOS_FORM_MA0;
          t = ({16'h0, fr} * {16'h0, PSOS_MA_FULL}) >> 16;
          c.milliamp_ua = t[15:0];
        end
        2'b01: begin
          c.form = PSOS_FORM_MA4;
          t = ({16'h0, fr} * {16'h0, PSOS_MA_FULL - PSOS_MA_LIVE}) >> 16;
          c.milliamp_ua = PSOS_MA_LIVE + t[15:0];
        end
        default: begin
          c.form = PSOS_FORM_PULSE;
          t = ({16'h0, fr} * {16'h0, ps}) >> 16;
          c.pulse_hz = t[15:0];
        end
      endcase
    end else begin
      c.digital = psos_status(f, fl, p);
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = 1'b0;
    if ((avs_read || avs_write) && !st_r.ack) begin
      st_nxt.ack = 1'b1;
      st_nxt.rdata = 32'h0;
      if (avs_read) begin
        case (avs_address)
          PSOS_ADDR_FUNC_A:   st_nxt.rdata = {24'h0, st_r.func_a};
          PSOS_ADDR_FUNC_B:   st_nxt.rdata = {24'h0, st_r.func_b};
          PSOS_ADDR_PSCALE_A: st_nxt.rdata = {16'h0, st_r.pscale_a};
          PSOS_ADDR_PSCALE_B: st_nxt.rdata = {16'h0, st_r.pscale_b};
          PSOS_ADDR_BUSPCT_A: st_nxt.rdata = {22'h0, st_r.buspct_a};
          PSOS_ADDR_BUSPCT_B: st_nxt.rdata = {22'h0, st_r.buspct_b};
          PSOS_ADDR_STATUS:   st_nxt.rdata = {30'h0, st_r.ch_b.digital, st_r.ch_a.digital};
          default:            st_nxt.rdata = PSOS_UNMAPPED;
        endcase
      end
    end
    // a write lands at the edge after its wait state, where the master sees it taken
    if (avs_write && st_r.ack) begin
        case (avs_address)
          PSOS_ADDR_FUNC_A:
            if (avs_byteenable[0]) st_nxt.func_a = avs_writedata[7:0];
          PSOS_ADDR_FUNC_B:
            if (avs_byteenable[0]) st_nxt.func_b = avs_writedata[7:0];
          PSOS_ADDR_PSCALE_A:
            if (&avs_byteenable[1:0] && avs_writedata[15:0] != 16'h0
                && avs_writedata[15:0] <= PSOS_PSCALE_MAX)
              st_nxt.pscale_a = avs_writedata[15:0];
          PSOS_ADDR_PSCALE_B:
            if (&avs_byteenable[1:0] && avs_writedata[15:0] != 16'h0
                && avs_writedata[15:0] <= PSOS_PSCALE_MAX)
              st_nxt.pscale_b = avs_writedata[15:0];
          PSOS_ADDR_BUSPCT_A:
            if (&avs_byteenable[1:0])
              st_nxt.buspct_a = (avs_writedata[15:0] > {6'h0, PSOS_BUSPCT_MAX}) ?
                                PSOS_BUSPCT_MAX : avs_writedata[9:0];
          PSOS_ADDR_BUSPCT_B:
            if (&avs_byteenable[1:0])
              st_nxt.buspct_b = (avs_writedata[15:0] > {6'h0, PSOS_BUSPCT_MAX}) ?
                                PSOS_BUSPCT_MAX : avs_writedata[9:0];
          default: ;
        endcase
    end
    // outputs follow the settings one cycle late; fine for slow indicator loops
    st_nxt.ch_a = psos_chan(st_r.func_a, st_r.pscale_a, st_r.buspct_a, flags, proc);
    st_nxt.ch_b = psos_chan(st_r.func_b, st_r.pscale_b, st_r.buspct_b, flags, proc);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{func_a: PSOS_FUNC_RST, func_b: PSOS_FUNC_RST,
                pscale_a: PSOS_PSCALE_RST, pscale_b: PSOS_PSCALE_RST,
                buspct_a: 10'h0, buspct_b: 10'h0, ack: 1'b0, rdata: 32'h0,
                ch_a: '{form: PSOS_FORM_DIG, digital: 1'b0, milliamp_ua: 16'h0,
                        pulse_hz: 16'h0},
                ch_b: '{form: PSOS_FORM_DIG, digital: 1'b0, milliamp_ua: 16'h0,
                        pulse_hz: 16'h0}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // one wait state per access: the answer needs the registered read mux
  assign avs_waitrequest = (avs_read || avs_write) && !st_r.ack;
  assign avs_readdata    = st_r.rdata;
  assign chan_a          = st_r.ch_a;
  assign chan_b          = st_r.ch_b;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_no_alarm_inv: assert property (@(posedge clk) disable iff (rst)
    (st_r.func_a == 8'h0a) ##1 (st_r.func_a == 8'h0a) |-> chan_a.digital != $past(flags.alarm))
    else $error("no alarm output not complement of alarm");
  a_unknown_off: assert property (@(posedge clk) disable iff (rst)
    (st_r.func_a > PSOS_F_BYPASS) |=> !chan_a.digital && chan_a.form == PSOS_FORM_DIG)
    else $error("unknown code drives output");
  a_live_zero: assert property (@(posedge clk) disable iff (rst)
    (chan_a.form == PSOS_FORM_MA4) |-> chan_a.milliamp_ua >= PSOS_MA_LIVE
      && chan_a.milliamp_ua <= PSOS_MA_FULL)
    else $error("4-20 mA output out of range");
  a_ma0_range: assert property (@(posedge clk) disable iff (rst)
    (chan_b.form == PSOS_FORM_MA0) |-> chan_b.milliamp_ua <= PSOS_MA_FULL)
    else $error("0-20 mA output over range");
  a_pulse_scale: assert property (@(posedge clk) disable iff (rst)
    (chan_a.form == PSOS_FORM_PULSE) |-> chan_a.pulse_hz <= $past(st_r.pscale_a))
    else $error("pulse rate above scaling");
  a_interlock_cfg: assert property (@(posedge clk) disable iff (rst)
    (st_r.func_b == 8'h0c && !flags.interlock_cfg) |=> !chan_b.digital)
    else $error("interlock shown while not configured");
  a_running_start: assert property (@(posedge clk) disable iff (rst)
    (st_r.func_a == 8'h03 && flags.start_cmd) |=> chan_a.digital)
    else $error("running not shown with start command");
  a_standby_warn: assert property (@(posedge clk) disable iff (rst)
    (st_r.func_a == 8'h02 && flags.warning) |=> !chan_a.digital)
    else $error("standby shown with warning");
  a_bus_answer: assert property (@(posedge clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered in one wait state");

  // per code: the output one cycle later follows the flag sampled with the code
  a_ready_shown: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_a == 8'h01 |=> chan_a.digital == $past(flags.ready))
    else $error("ready output wrong");
  a_standby_shown: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_a == 8'h02 && flags.ready && !flags.start_cmd && !flags.warning |=> chan_a.digital)
    else $error("standby not shown");
  a_running_freq: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_a == 8'h03 && proc.out_freq > PSOS_HZ01 |=> chan_a.digital)
    else $error("running not shown above minimum frequency");
  a_running_idle: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_a == 8'h03 && !flags.start_cmd && proc.out_freq <= PSOS_HZ01 |=> !chan_a.digital)
    else $error("running shown while idle");
  a_at_ref_off: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_b == 8'h04 && !flags.at_ref |=> !chan_b.digital)
    else $error("at reference shown off reference");
  a_no_warn_run: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_b == 8'h05 && flags.warning |=> !chan_b.digital)
    else $error("running no warning shown with warning");
  a_local_shown: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_b == 8'h06 |=> chan_b.digital == $past(flags.local_ref))
    else $error("local reference output wrong");
  a_remote_shown: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_b == 8'h07 |=> chan_b.digital != $past(flags.local_ref))
    else $error("remote reference output wrong");
  a_alarm_shown: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_b == 8'h08 |=> chan_b.digital == $past(flags.alarm))
    else $error("alarm output wrong");
  a_alarm_warn: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_b == 8'h09 && flags.warning |=> chan_b.digital)
    else $error("alarm or warning missed a warning");
  a_cur_limit: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_a == 8'h0b && proc.current > proc.current_limit_setting |=> chan_a.digital)
    else $error("current limit not shown");
  a_start_shown: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_b == 8'h0d |=> chan_b.digital == $past(flags.start_cmd))
    else $error("start command output wrong");
  a_reverse_shown: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_a == 8'h0e |=> chan_a.digital == $past(flags.reverse))
    else $error("reversing output wrong");
  a_sleep_shown: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_b == 8'h12 |=> chan_b.digital == $past(flags.sleep_mode))
    else $error("sleep output wrong");
  a_freq_range: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_a == 8'h15 && flags.freq_high |=> chan_a.digital)
    else $error("frequency range missed high frequency");
  a_cur_range: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_b == 8'h18 && flags.cur_low |=> chan_b.digital)
    else $error("current range missed low current");
  a_relay_shown: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_a == 8'h1b |=> chan_a.digital == $past(flags.option_relay))
    else $error("option relay output wrong");
  a_fire_shown: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_b == PSOS_F_FIRE |=> chan_b.digital == $past(flags.fire_mode))
    else $error("override active output wrong");
  a_bypass_shown: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_a == PSOS_F_BYPASS |=> chan_a.digital == $past(flags.fire_bypass))
    else $error("override bypass output wrong");
  a_none_off: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_b == PSOS_FUNC_RST |=> !chan_b.digital && chan_b.form == PSOS_FORM_DIG)
    else $error("no function drives output");
  a_digital_form: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_a <= PSOS_F_LAST_DIG |=> chan_a.form == PSOS_FORM_DIG)
    else $error("status code left digital form");
  a_analog_quiet: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_a >= PSOS_F_ANA_FIRST && st_r.func_a <= PSOS_F_ANA_LAST |=> !chan_a.digital)
    else $error("process value code drives 24 V");
  a_ma4_form: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_a == 8'h1e |=> chan_a.form == PSOS_FORM_MA4)
    else $error("frequency 4-20 mA form wrong");
  a_pulse_form: assert property (
    @(posedge clk) disable iff (rst)
    st_r.func_b == 8'h2e |=> chan_b.form == PSOS_FORM_PULSE)
    else $error("bus percent pulse form wrong");

endmodule

// ### psos_meter.sv
// partner: indicating instrument reading one selector output
module psos_meter
  import psos_pkg::*;
(
  input  wire psos_chan_s chan,
  output logic [15:0]     volts,
  output logic [15:0]     level
);
  // a current loop reads microamps, a counter reads pulses per second;
  // an unknown form reads as nothing, like an open loop
  always_comb begin
    volts = (chan.form == PSOS_FORM_DIG && chan.digital) ? 16'h0018 : 16'h0000;
    case (chan.form)
      PSOS_FORM_MA0, PSOS_FORM_MA4: level = chan.milliamp_ua;
      PSOS_FORM_PULSE: level = chan.pulse_hz;
      default: level = 16'h0000;
    endcase
  end
endmodule

// ### psos_selector_tb.sv
// testbench: registers, status codes and scaled outputs of the selector
module psos_selector_tb
  import psos_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  psos_flags_s flags;
  psos_proc_s  proc;
  psos_chan_s  chan_a;
  psos_chan_s  chan_b;
  logic [15:0] volts_a;
  logic [15:0] level_a;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cycles = 0;
  localparam logic [22:0] PATS [5] = '{23'h000000, 23'h7fffff, 23'h555555, 23'h2aaaaa,
                                      23'h400000};

  psos_selector DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flags(flags),
    .proc(proc), .chan_a(chan_a), .chan_b(chan_b));
  psos_meter meter_a (.chan(chan_a), .volts(volts_a), .level(level_a));

  always #2.5 clk = ~clk;
  // the whole run needs about 2450 cycles; far beyond that means a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // compares and bus cycles
  // ----------------------------------------------------------------
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  // full scale may land one count short of the ideal value
  task automatic chk_near(input string w, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (^g === 1'bx || g + 1 < e || g > e + 1) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic bus(input logic wr_n, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr_n;
    avs_read <= !wr_n;
    // waitrequest and read data are taken at the rising edge; release at that same edge
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge clk);
    end
    chk("wait states", 32'h1, 32'(n));
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask
  task automatic rdchk(input string w, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(w, e, q);
  endtask
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // expected values
  // ----------------------------------------------------------------
  function automatic logic exp_dig(input logic [7:0] c, input psos_flags_s f,
                                   input psos_proc_s p);
    logic        run;
    logic [48:0] v;
    run = f.start_cmd | (p.out_freq > 16'h0001);
    v = {f.fire_bypass, f.fire_mode, 18'h00000,
         f.mains_imbal, f.option_relay, f.ref_range, f.fb_range,
         f.cur_low | f.cur_high, f.cur_high, f.cur_low,
         f.freq_low | f.freq_high, f.freq_high, f.freq_low,
         f.sleep_mode, f.auto_mode, f.hand_mode, f.thermal_warn, f.reverse,
         f.start_cmd, f.interlock_in & f.interlock_cfg,
         p.current > p.current_limit_setting,
         !f.alarm, f.alarm | f.warning, f.alarm,
         !f.local_ref, f.local_ref, f.start_cmd & !f.warning,
         run & f.at_ref, run, f.ready & !f.start_cmd & !f.warning,
         f.ready, 1'b0};
    return (c < 8'h31) ? v[c[5:0]] : 1'b0;
  endfunction
  function automatic psos_form_e exp_form(input logic [7:0] c);
    logic [7:0] k;
    k = (c - 8'h1d) % 8'h03;
    if (c < 8'h1d || c > 8'h2e) return PSOS_FORM_DIG;
    return (k == 8'h00) ? PSOS_FORM_MA0 : (k == 8'h01) ? PSOS_FORM_MA4 : PSOS_FORM_PULSE;
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] q;
    chk("reset form", 32'(PSOS_FORM_DIG), 32'(chan_a.form));
    rdchk("func a reset", PSOS_ADDR_FUNC_A, 32'h0);
    rdchk("func b reset", PSOS_ADDR_FUNC_B, 32'h0);
    rdchk("pscale b reset", PSOS_ADDR_PSCALE_B, 32'h1388);
    rdchk("unmapped", 4'hf, 32'hdead0000);
    wr(4'hf, 32'h1);
    bus(1'b1, PSOS_ADDR_FUNC_A, 32'h3, 4'he, q);
    rdchk("func a lane", PSOS_ADDR_FUNC_A, 32'h0);
    wr(PSOS_ADDR_PSCALE_A, 32'h0);
    wr(PSOS_ADDR_PSCALE_A, 32'h7d01);
    rdchk("pscale refused", PSOS_ADDR_PSCALE_A, 32'h1388);
    wr(PSOS_ADDR_PSCALE_A, 32'h7d00);
    rdchk("pscale max", PSOS_ADDR_PSCALE_A, 32'h7d00);
    wr(PSOS_ADDR_BUSPCT_A, 32'h3e9);
    rdchk("percent clamp", PSOS_ADDR_BUSPCT_A, 32'h3e8);
  endtask
  // codes 0x00 to 0x32 then 255 on output a, 0x30 down to 0x00 then 0xff, 0xfe, 0x31 on b, under several flag patterns
  task automatic t_digital();
    logic [7:0] c;
    logic [7:0] cb;
    for (int p = 0; p < 5; p++) begin
      @(posedge clk);
      flags <= psos_flags_s'(PATS[p]);
      proc.out_freq <= p[0] ? 16'h0002 : 16'h0001;
      proc.current <= p[1] ? 16'h0065 : 16'h0064;
      for (int i = 0; i < 52; i++) begin
        c = (i == 51) ? 8'hff : 8'(i);
        cb = 8'h30 - c;
        wr(PSOS_ADDR_FUNC_A, 32'(c));
        wr(PSOS_ADDR_FUNC_B, 32'(cb));
        settle();
        chk("form a", 32'(exp_form(c)), 32'(chan_a.form));
        chk("form b", 32'(exp_form(cb)), 32'(chan_b.form));
        if (exp_form(c) == PSOS_FORM_DIG) begin
          chk("digital a", 32'(exp_dig(c, flags, proc)), 32'(chan_a.digital));
          chk("volts a", exp_dig(c, flags, proc) ? 32'h18 : 32'h0, 32'(volts_a));
        end
        if (exp_form(cb) == PSOS_FORM_DIG) begin
          chk("digital b", 32'(exp_dig(cb, flags, proc)), 32'(chan_b.digital));
        end
      end
    end
    wr(PSOS_ADDR_FUNC_A, 32'h1);
    wr(PSOS_ADDR_FUNC_B, 32'ha);
    settle();
    rdchk("status", PSOS_ADDR_STATUS,
          {30'h0, exp_dig(8'h0a, flags, proc), exp_dig(8'h01, flags, proc)});
  endtask
  // each source at its minimum, midpoint and maximum in all three forms
  task automatic t_analog();
    logic [31:0] e;
    for (int t = 0; t < 3; t++) begin
      @(posedge clk);
      proc.out_freq <= 16'(t * 16'h03e8);
      proc.ext_ref <= 16'(16'h0064 + t * 16'h0064);
      proc.feedback <= 16'(16'h03e8 + t * 16'h07d0);
      proc.current <= 16'(t * 16'h00c8);
      proc.power <= 16'(t * 16'h0190);
      wr(PSOS_ADDR_BUSPCT_A, 32'(t * 16'h01f4));
      for (int i = 29; i < 47; i++) begin
        wr(PSOS_ADDR_FUNC_A, 32'(i));
        settle();
        case (exp_form(8'(i)))
          PSOS_FORM_MA0: e = 32'(t * 16'h2710);
          PSOS_FORM_MA4: e = 32'(16'h0fa0 + t * 16'h1f40);
          default: e = 32'(t * 16'h3e80);
        endcase
        chk_near("level a", e, 32'(level_a));
      end
    end
    wr(PSOS_ADDR_FUNC_B, 32'h1f);
    settle();
    chk_near("pulse b", 32'h1388, 32'(chan_b.pulse_hz));
    wr(PSOS_ADDR_FUNC_B, 32'h24);
    settle();
    chk_near("ma b", 32'(PSOS_MA_FULL), 32'(chan_b.milliamp_ua));
  endtask

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    flags = '0;
    proc = '0;
    proc.max_freq = 16'h07d0;
    proc.min_ref = 16'h0064;
    proc.max_ref = 16'h012c;
    proc.min_feedback = 16'h03e8;
    proc.max_feedback = 16'h1388;
    proc.max_current = 16'h0190;
    proc.nominal_power = 16'h0320;
    proc.current_limit_setting = 16'h0064;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_digital();
    t_analog();
    give_verdict();
  end
endmodule
